/* File: rtl/skp_pkg.sv */
// Constants for the skip-on-flag execution block: codes, bit positions,
// register offsets and reset values.
// Assumes a 10-bit instruction word and a 32-bit AXI4-Lite register bus.
package skp_pkg;
   // Instruction codes
   localparam logic [9:0] CODE_EXT_REQ = 10'h038;
   localparam logic [9:0] CODE_EXT_PIN = 10'h03A;
   localparam logic [9:0] CODE_PWR_DOWN = 10'h003;
   localparam logic [9:0] CODE_TIMER_A = 10'h280;
   localparam logic [9:0] CODE_TIMER_B = 10'h281;
   // Bits of irq_ctrl_reg_a and irq_ctrl_reg_b
   localparam int EXT_IRQ_EN_BIT = 0;
   localparam int TIMER_A_IRQ_EN_BIT = 2;
   localparam int TIMER_B_IRQ_EN_BIT = 3;
   localparam int PIN_POL_BIT = 2;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h0C;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'h10;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h14;
   // Event bits, shared by status, clear and enable
   localparam int EVT_EXT_SKIP = 0;
   localparam int EVT_PIN_SKIP = 1;
   localparam int EVT_PD_SKIP = 2;
   localparam int EVT_TA_SKIP = 3;
   localparam int EVT_TB_SKIP = 4;
   localparam int EVT_SQUASH = 5;
   localparam int EVT_W = 6;
   // Reset values
   localparam logic [3:0] CTRL_A_RST = 4'h0;
   localparam logic [3:0] CTRL_B_RST = 4'h0;
   localparam logic [5:0] EVT_RST = 6'h00;
   localparam logic PIN_LEVEL_RST = 1'b1;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/skp_dec_if.sv */
// Carrier between the core and its instruction decoder.
// Assumes both ends sit on the same clock; the decode is combinational.
`timescale 1ns/1ns
interface skp_dec_if;
   logic [9:0] code;
   logic ext_req;
   logic ext_pin;
   logic pwr_down;
   logic timer_a;
   logic timer_b;
   modport dec (input code, output ext_req, ext_pin, pwr_down, timer_a, timer_b);
   modport core (output code, input ext_req, ext_pin, pwr_down, timer_a, timer_b);
endinterface

/* File: rtl/skp_decode.sv */
// Decoder for the five skip instructions.
// Assumes the code is stable while the core samples the result.
`timescale 1ns/1ns
module skp_decode
(
   skp_dec_if.dec bus
);
   // Full 10-bit compare, so neighbouring codes never alias
   always_comb
   begin
      bus.ext_req = (bus.code == skp_pkg::CODE_EXT_REQ);
      bus.ext_pin = (bus.code == skp_pkg::CODE_EXT_PIN);
      bus.pwr_down = (bus.code == skp_pkg::CODE_PWR_DOWN);
      bus.timer_a = (bus.code == skp_pkg::CODE_TIMER_A);
      bus.timer_b = (bus.code == skp_pkg::CODE_TIMER_B);
   end
endmodule

/* File: rtl/skp_pin_sync.sv */
// Three-stage synchroniser for the external interrupt input pin.
// Assumes the pin is asynchronous to core_clk_in.
`timescale 1ns/1ns
module skp_pin_sync
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic pin_in,
   output logic level_out
);
   logic meta;
   logic stage2;
   logic stage3;

   // Only stage2 reads meta; level moves once stage2 and stage3 agree
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta <= skp_pkg::PIN_LEVEL_RST;
         stage2 <= skp_pkg::PIN_LEVEL_RST;
         stage3 <= skp_pkg::PIN_LEVEL_RST;
         level_out <= skp_pkg::PIN_LEVEL_RST;
      end
      else
      begin
         meta <= pin_in;
         stage2 <= meta;
         stage3 <= stage2;
         if (stage2 == stage3)
         begin
            level_out <= stage3;
         end
      end
   end
endmodule

/* File: rtl/skp_core.sv */
// Skip-on-flag execution block of a 4-bit CPU, with AXI4-Lite registers.
// Assumes one instruction word offered per instr_valid_in cycle, flag set
// pulses from logic on core_clk_in, and an asynchronous interrupt pin.
//
// Operation
// - With ext enable clear, the ext-request skip skips when its flag is 1 and clears it.
// - The ext enable is bit 0 of control register A; when set the ext skip is a no-op.
// - Code 03A is the pin-level skip, one word, one cycle, carry untouched.
// - With polarity select 0 the pin-level skip skips when the pin is low.
// - Polarity select is bit 2 of control register B; at 1 the skip is taken on a high pin.
// - Code 003 skips when the power-down flag is 1 and leaves that flag alone.
// - Code 280 is the timer A skip, one word, one cycle.
// - With timer A enable clear, the timer A skip skips on its flag and clears it.
// - Timer A enable is bit 2 of control register A; when set the skip is a no-op.
// - Code 281 is the timer B skip, one word, one cycle.
// - With timer B enable clear, the timer B skip skips on its flag and clears it.
// - Timer B enable is bit 3 of control register A; when set the skip is a no-op.
// - Code 038 is the ext-request skip, one word, one cycle.
`timescale 1ns/1ns
module skp_core
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Instruction stream
   input wire logic instr_valid_in,
   input wire logic [9:0] instr_code_in,
   // Flag sources
   input wire logic ext_request_set_in,
   input wire logic timer_a_request_set_in,
   input wire logic timer_b_request_set_in,
   input wire logic power_down_flag_in,
   input wire logic ext_irq_pin_in,
   // Execution results
   output logic skip_pending_out,
   output logic pc_advance_out,
   output logic squash_out,
   output logic ext_request_flag_out,
   output logic timer_a_request_flag_out,
   output logic timer_b_request_flag_out,
   output logic irq_out,
   // AXI4-Lite slave
   input wire logic axi_awvalid_in,
   output logic axi_awready_out,
   input wire logic [7:0] axi_awaddr_in,
   input wire logic axi_wvalid_in,
   output logic axi_wready_out,
   input wire logic [31:0] axi_wdata_in,
   input wire logic [3:0] axi_wstrb_in,
   output logic axi_bvalid_out,
   input wire logic axi_bready_in,
   output logic [1:0] axi_bresp_out,
   input wire logic axi_arvalid_in,
   output logic axi_arready_out,
   input wire logic [7:0] axi_araddr_in,
   output logic axi_rvalid_out,
   input wire logic axi_rready_in,
   output logic [31:0] axi_rdata_out,
   output logic [1:0] axi_rresp_out
);
   skp_dec_if dec_bus ();
   logic [3:0] irq_ctrl_reg_a;
   logic [3:0] irq_ctrl_reg_b;
   logic [5:0] evt_status;
   logic [5:0] evt_enable;
   logic pin_level;
   logic exec;
   logic squash;
   logic ext_take;
   logic pin_take;
   logic pd_take;
   logic ta_take;
   logic tb_take;
   logic [5:0] evt_set;
   logic [5:0] evt_clr;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic w_held;
   logic do_write;
   logic [31:0] next_rdata;
   logic next_rerr;

   assign dec_bus.code = instr_code_in;

   skp_decode u_decode
   (
      .bus(dec_bus)
   );

   skp_pin_sync u_pin_sync
   (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .pin_in(ext_irq_pin_in),
      .level_out(pin_level)
   );

   // Word after a taken skip is squashed instead of executed
   assign exec = instr_valid_in && !skip_pending_out;
   assign squash = instr_valid_in && skip_pending_out;

   // Skip decisions; an enable bit set turns the instruction into a no-op
   assign ext_take = exec && dec_bus.ext_req && !irq_ctrl_reg_a[skp_pkg::EXT_IRQ_EN_BIT]
      && ext_request_flag_out;
   assign pin_take = exec && dec_bus.ext_pin
      && (pin_level == irq_ctrl_reg_b[skp_pkg::PIN_POL_BIT]);
   assign pd_take = exec && dec_bus.pwr_down && power_down_flag_in;
   assign ta_take = exec && dec_bus.timer_a && !irq_ctrl_reg_a[skp_pkg::TIMER_A_IRQ_EN_BIT]
      && timer_a_request_flag_out;
   assign tb_take = exec && dec_bus.timer_b && !irq_ctrl_reg_a[skp_pkg::TIMER_B_IRQ_EN_BIT]
      && timer_b_request_flag_out;

   // Skip state and PC strobes; one word per cycle, no carry write path
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         skip_pending_out <= 1'b0;
         pc_advance_out <= 1'b0;
         squash_out <= 1'b0;
      end
      else
      begin
         pc_advance_out <= instr_valid_in;
         squash_out <= squash;
         if (instr_valid_in)
         begin
            skip_pending_out <= ext_take || pin_take || pd_take || ta_take || tb_take;
         end
      end
   end

   // Request flags: a set in the same cycle beats the skip's clear
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ext_request_flag_out <= 1'b0;
         timer_a_request_flag_out <= 1'b0;
         timer_b_request_flag_out <= 1'b0;
      end
      else
      begin
         ext_request_flag_out <= ext_request_set_in
            || (ext_request_flag_out && !ext_take);
         timer_a_request_flag_out <= timer_a_request_set_in
            || (timer_a_request_flag_out && !ta_take);
         timer_b_request_flag_out <= timer_b_request_set_in
            || (timer_b_request_flag_out && !tb_take);
      end
   end

   // Event sources, one bit each
   assign evt_set = {squash, tb_take, ta_take, pd_take, pin_take, ext_take};
   assign evt_clr = (do_write && aw_addr == skp_pkg::OFS_EVT_CLEAR) ? w_data[5:0] : 6'h00;

   // Sticky events; a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         evt_status <= skp_pkg::EVT_RST;
         irq_out <= 1'b0;
      end
      else
      begin
         evt_status <= (evt_status & ~evt_clr) | evt_set;
         irq_out <= |(((evt_status & ~evt_clr) | evt_set) & evt_enable);
      end
   end

   // Write address and data taken in either order, then one response
   assign do_write = aw_held && w_held && !axi_bvalid_out;

   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         axi_awready_out <= 1'b1;
         axi_wready_out <= 1'b1;
         axi_bvalid_out <= 1'b0;
         axi_bresp_out <= skp_pkg::RESP_OKAY;
      end
      else
      begin
         if (axi_awvalid_in && axi_awready_out)
         begin
            aw_held <= 1'b1;
            aw_addr <= axi_awaddr_in;
            axi_awready_out <= 1'b0;
         end
         if (axi_wvalid_in && axi_wready_out)
         begin
            w_held <= 1'b1;
            w_data <= axi_wdata_in;
            axi_wready_out <= 1'b0;
         end
         if (do_write)
         begin
            axi_bvalid_out <= 1'b1;
            axi_bresp_out <= (aw_addr == skp_pkg::OFS_CTRL_A || aw_addr == skp_pkg::OFS_CTRL_B
               || aw_addr == skp_pkg::OFS_EVT_CLEAR || aw_addr == skp_pkg::OFS_EVT_ENABLE)
               ? skp_pkg::RESP_OKAY : skp_pkg::RESP_SLVERR;
         end
         if (axi_bvalid_out && axi_bready_in)
         begin
            axi_bvalid_out <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            axi_awready_out <= 1'b1;
            axi_wready_out <= 1'b1;
         end
      end
   end

   // Writable registers; only byte lane 0 carries bits
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         irq_ctrl_reg_a <= skp_pkg::CTRL_A_RST;
         irq_ctrl_reg_b <= skp_pkg::CTRL_B_RST;
         evt_enable <= skp_pkg::EVT_RST;
      end
      else if (do_write && axi_wstrb_in[0] | 1'b1 && w_held)
      begin
         case (aw_addr)
            skp_pkg::OFS_CTRL_A: irq_ctrl_reg_a <= w_data[3:0];
            skp_pkg::OFS_CTRL_B: irq_ctrl_reg_b <= w_data[3:0];
            skp_pkg::OFS_EVT_ENABLE: evt_enable <= w_data[5:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped and write-only offsets answer SLVERR with zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;
      case (axi_araddr_in)
         skp_pkg::OFS_CTRL_A: next_rdata = {28'h0000000, irq_ctrl_reg_a};
         skp_pkg::OFS_CTRL_B: next_rdata = {28'h0000000, irq_ctrl_reg_b};
         skp_pkg::OFS_FLAGS: next_rdata = {26'h0, skip_pending_out, pin_level,
            power_down_flag_in, timer_b_request_flag_out, timer_a_request_flag_out,
            ext_request_flag_out};
         skp_pkg::OFS_EVT_STATUS: next_rdata = {26'h0, evt_status};
         skp_pkg::OFS_EVT_ENABLE: next_rdata = {26'h0, evt_enable};
         default: next_rerr = 1'b1;
      endcase
   end

   // Read channel: one outstanding read, answer one cycle after address
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         axi_arready_out <= 1'b1;
         axi_rvalid_out <= 1'b0;
         axi_rdata_out <= 32'h0000_0000;
         axi_rresp_out <= skp_pkg::RESP_OKAY;
      end
      else
      begin
         if (axi_arvalid_in && axi_arready_out)
         begin
            axi_arready_out <= 1'b0;
            axi_rvalid_out <= 1'b1;
            axi_rdata_out <= next_rdata;
            axi_rresp_out <= next_rerr ? skp_pkg::RESP_SLVERR : skp_pkg::RESP_OKAY;
         end
         else if (axi_rvalid_out && axi_rready_in)
         begin
            axi_rvalid_out <= 1'b0;
            axi_arready_out <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   a_ext_skip_clear: assert property (
      exec && dec_bus.ext_req && !irq_ctrl_reg_a[0] && ext_request_flag_out
      && !ext_request_set_in |=> skip_pending_out && !ext_request_flag_out)
      else $error("ext request skip did not skip and clear");
   a_ext_skip_nop: assert property (
      exec && dec_bus.ext_req && irq_ctrl_reg_a[0] |=> !skip_pending_out
      && (ext_request_flag_out == $past(ext_request_flag_out) || $past(ext_request_set_in)))
      else $error("enabled ext request skip was not a no-op");
   a_pin_low_skip: assert property (
      exec && instr_code_in == 10'h03A && !irq_ctrl_reg_b[2] |=> skip_pending_out == !$past(pin_level))
      else $error("pin skip wrong with polarity 0");
   a_pin_high_skip: assert property (
      exec && instr_code_in == 10'h03A && irq_ctrl_reg_b[2] |=> skip_pending_out == $past(pin_level))
      else $error("pin skip wrong with polarity 1");
   a_pd_skip: assert property (
      exec && instr_code_in == 10'h003 |=> skip_pending_out == $past(power_down_flag_in))
      else $error("power-down skip wrong");
   a_ta_skip_clear: assert property (
      exec && instr_code_in == 10'h280 && !irq_ctrl_reg_a[2] && timer_a_request_flag_out
      && !timer_a_request_set_in |=> skip_pending_out && !timer_a_request_flag_out)
      else $error("timer A skip did not skip and clear");
   a_ta_skip_nop: assert property (
      exec && instr_code_in == 10'h280 && irq_ctrl_reg_a[2] |=> !skip_pending_out)
      else $error("enabled timer A skip was not a no-op");
   a_tb_skip_clear: assert property (
      exec && instr_code_in == 10'h281 && !irq_ctrl_reg_a[3] && timer_b_request_flag_out
      && !timer_b_request_set_in |=> skip_pending_out && !timer_b_request_flag_out)
      else $error("timer B skip did not skip and clear");
   a_tb_skip_nop: assert property (
      exec && instr_code_in == 10'h281 && irq_ctrl_reg_a[3] |=> !skip_pending_out)
      else $error("enabled timer B skip was not a no-op");
   a_squash_word: assert property (
      skip_pending_out && instr_valid_in |=> !skip_pending_out && squash_out && pc_advance_out)
      else $error("skipped word was not squashed");
   a_set_wins: assert property (
      ext_request_set_in || timer_a_request_set_in || timer_b_request_set_in
      |=> (!$past(ext_request_set_in) || ext_request_flag_out)
      && (!$past(timer_a_request_set_in) || timer_a_request_flag_out)
      && (!$past(timer_b_request_set_in) || timer_b_request_flag_out))
      else $error("flag set lost against clear");
   a_ext_code_match: assert property (
      exec && instr_code_in == 10'h038 && !irq_ctrl_reg_a[0] && ext_request_flag_out
      |=> skip_pending_out)
      else $error("code 038 not decoded as ext skip");
endmodule

/* File: testbench/tb_skp_core.sv */
// Bench for the skip-on-flag block: AXI4-Lite tasks, instruction issue, flag checks.
// Assumes one clock, flag sources driven here and the pin level synced in the block.
`timescale 1ns/1ns
module tb_skp_core;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic [9:0] instr_code_in = 10'h000;
   logic [2:0] set_v = 3'h0;
   logic power_down_flag_in = 1'b0;
   logic ext_irq_pin_in = 1'b1;
   logic skip_pending_out, pc_advance_out, squash_out, irq_out;
   logic [2:0] flag_v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp;
   logic [9:0] codes [3] = '{skp_pkg::CODE_EXT_REQ, skp_pkg::CODE_TIMER_A, skp_pkg::CODE_TIMER_B};
   int en_bit [3] = '{0, 2, 3};
   int bad_count = 0;
   int n_checks = 0;

   // Free-running 25 MHz clock
   always #20 core_clk_in = ~core_clk_in;

   skp_core skp_core_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .instr_valid_in(instr_valid_in), .instr_code_in(instr_code_in),
      .ext_request_set_in(set_v[0]), .timer_a_request_set_in(set_v[1]),
      .timer_b_request_set_in(set_v[2]), .power_down_flag_in(power_down_flag_in),
      .ext_irq_pin_in(ext_irq_pin_in), .skip_pending_out(skip_pending_out),
      .pc_advance_out(pc_advance_out), .squash_out(squash_out),
      .ext_request_flag_out(flag_v[0]), .timer_a_request_flag_out(flag_v[1]),
      .timer_b_request_flag_out(flag_v[2]), .irq_out(irq_out),
      .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_awaddr_in(awaddr),
      .axi_wvalid_in(wvalid), .axi_wready_out(wready), .axi_wdata_in(wdata),
      .axi_wstrb_in(4'hF), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
      .axi_bresp_out(bresp), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
      .axi_araddr_in(araddr), .axi_rvalid_out(rvalid), .axi_rready_in(rready),
      .axi_rdata_out(rdata), .axi_rresp_out(rresp));

   task automatic close_out;
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   // Offers AW and W together, drops each when taken, then waits for B
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge core_clk_in);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge core_clk_in);
         if (!aw_done && awready === 1'b1)
         begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && wready === 1'b1)
         begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      while (bvalid !== 1'b1)
         @(posedge core_clk_in);
      bready <= 1'b0;
      chk_word({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge core_clk_in);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do
         @(posedge core_clk_in);
      while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         @(posedge core_clk_in);
      rready <= 1'b0;
      d = rdata;
      chk_word({30'h0, rresp}, {30'h0, er});
   endtask

   // One valid word; results are sampled just after the taking edge
   task automatic exec(input logic [9:0] c);
      @(posedge core_clk_in);
      instr_valid_in <= 1'b1;
      instr_code_in <= c;
      @(posedge core_clk_in);
      instr_valid_in <= 1'b0;
      #1;
   endtask

   task automatic set_flag(input int i);
      @(posedge core_clk_in);
      set_v[i] <= 1'b1;
      @(posedge core_clk_in);
      set_v <= 3'h0;
      #1;
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      #400000;
      bad_count++;
      close_out();
   end

   // Main sequence
   initial
   begin
      repeat (10) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      axi_read(skp_pkg::OFS_CTRL_A, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h0);
      axi_read(skp_pkg::OFS_CTRL_B, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h0);
      axi_read(skp_pkg::OFS_FLAGS, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h10);
      axi_read(skp_pkg::OFS_EVT_CLEAR, skp_pkg::RESP_SLVERR, rd);
      chk_word(rd, 32'h0);
      axi_read(8'h3C, skp_pkg::RESP_SLVERR, rd);
      axi_write(skp_pkg::OFS_FLAGS, 32'h3F, skp_pkg::RESP_SLVERR);
      // Interrupt: raise, mask, unmask, clear
      axi_write(skp_pkg::OFS_EVT_ENABLE, 32'h1, skp_pkg::RESP_OKAY);
      set_flag(0);
      exec(skp_pkg::CODE_EXT_REQ);
      exec(10'h000);
      repeat (2) @(posedge core_clk_in);
      #1 chk_bit(irq_out, 1'b1);
      chk_bit(pc_advance_out, 1'b0);
      chk_bit(squash_out, 1'b0);
      axi_read(skp_pkg::OFS_EVT_STATUS, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h21);
      axi_write(skp_pkg::OFS_EVT_ENABLE, 32'h0, skp_pkg::RESP_OKAY);
      repeat (2) @(posedge core_clk_in);
      #1 chk_bit(irq_out, 1'b0);
      axi_write(skp_pkg::OFS_EVT_ENABLE, 32'h1, skp_pkg::RESP_OKAY);
      axi_write(skp_pkg::OFS_EVT_CLEAR, 32'h3F, skp_pkg::RESP_OKAY);
      repeat (2) @(posedge core_clk_in);
      #1 chk_bit(irq_out, 1'b0);
      axi_read(skp_pkg::OFS_EVT_STATUS, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h0);
      // Three request skips: taken, squash, not taken, enable set
      for (int i = 0; i < 3; i++)
      begin
         set_flag(i);
         exec(codes[i]);
         chk_bit(skip_pending_out, 1'b1);
         chk_bit(flag_v[i], 1'b0);
         chk_bit(pc_advance_out, 1'b1);
         exec(codes[i]);
         chk_bit(squash_out, 1'b1);
         chk_bit(skip_pending_out, 1'b0);
         chk_bit(pc_advance_out, 1'b1);
         exec(codes[i]);
         chk_bit(skip_pending_out, 1'b0);
         chk_bit(squash_out, 1'b0);
         axi_write(skp_pkg::OFS_CTRL_A, 32'h1 << en_bit[i], skp_pkg::RESP_OKAY);
         axi_read(skp_pkg::OFS_CTRL_A, skp_pkg::RESP_OKAY, rd);
         chk_word(rd, 32'h1 << en_bit[i]);
         set_flag(i);
         exec(codes[i]);
         chk_bit(skip_pending_out, 1'b0);
         chk_bit(flag_v[i], 1'b1);
         axi_write(skp_pkg::OFS_CTRL_A, 32'h0, skp_pkg::RESP_OKAY);
         exec(codes[i]);
         exec(10'h000);
      end
      axi_read(skp_pkg::OFS_EVT_STATUS, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h39);
      // A squashed skip word leaves its own flag alone
      set_flag(2);
      set_flag(0);
      exec(skp_pkg::CODE_EXT_REQ);
      exec(skp_pkg::CODE_TIMER_B);
      chk_bit(flag_v[2], 1'b1);
      exec(skp_pkg::CODE_TIMER_B);
      exec(10'h000);
      // Set and clear in one cycle: set wins
      set_flag(0);
      @(posedge core_clk_in);
      set_v[0] <= 1'b1;
      instr_valid_in <= 1'b1;
      instr_code_in <= skp_pkg::CODE_EXT_REQ;
      @(posedge core_clk_in);
      set_v <= 3'h0;
      instr_valid_in <= 1'b0;
      #1 chk_bit(flag_v[0], 1'b1);
      chk_bit(skip_pending_out, 1'b1);
      exec(10'h000);
      exec(skp_pkg::CODE_EXT_REQ);
      exec(10'h000);
      // Power-down skip
      @(posedge core_clk_in);
      power_down_flag_in <= 1'b1;
      exec(skp_pkg::CODE_PWR_DOWN);
      chk_bit(skip_pending_out, 1'b1);
      axi_read(skp_pkg::OFS_FLAGS, skp_pkg::RESP_OKAY, rd);
      chk_word(rd, 32'h38);
      exec(10'h000);
      @(posedge core_clk_in);
      power_down_flag_in <= 1'b0;
      exec(skp_pkg::CODE_PWR_DOWN);
      chk_bit(skip_pending_out, 1'b0);
      // Pin-level skip over both polarities and both levels
      for (int k = 0; k < 4; k++)
      begin
         axi_write(skp_pkg::OFS_CTRL_B, (k >> 1) << 2, skp_pkg::RESP_OKAY);
         @(posedge core_clk_in);
         ext_irq_pin_in <= k[0];
         repeat (8) @(posedge core_clk_in);
         exec(skp_pkg::CODE_EXT_PIN);
         chk_bit(skip_pending_out, k[0] == k[1]);
         exec(10'h000);
      end
      close_out();
   end
endmodule
